/* pkg/sds_pkg.sv */
// shared constants and types of the system data / address / sleep command handler
package sds_pkg;

    // ************************************************************
    // register byte offsets on the apb
    // ************************************************************
    localparam logic [7:0] OFS_CMD     = 8'h00; // command launch
    localparam logic [7:0] OFS_ARG     = 8'h04; // 16-bit offset argument
    localparam logic [7:0] OFS_NEWA_LO = 8'h08; // new address bytes 0..3
    localparam logic [7:0] OFS_NEWA_HI = 8'h0c; // new address bytes 4..5
    localparam logic [7:0] OFS_STATUS  = 8'h10; // busy, error, sleep state
    localparam logic [7:0] OFS_RSP     = 8'h14; // response byte, read pops
    localparam logic [7:0] OFS_CURA_LO = 8'h18; // address in effect, bytes 0..3
    localparam logic [7:0] OFS_CURA_HI = 8'h1c; // address in effect, bytes 4..5
    localparam logic [7:0] OFS_CFG     = 8'h20; // privacy, init list info
    localparam logic [7:0] OFS_STORE   = 8'h24; // user store byte write

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CMD_OP_LSB   = 0;  // 2-bit opcode
    localparam int CMD_MODE_LSB = 4;  // 4-bit read mode
    localparam int CMD_CNT_LSB  = 8;  // 6-bit byte count
    localparam int ST_BUSY      = 0;
    localparam int ST_ERR       = 1;
    localparam int ST_SLP_LSB   = 4;  // 2-bit configured level
    localparam int ST_NORM      = 8;  // normal sleep permitted now
    localparam int ST_DEEP      = 9;  // deep sleep permitted now
    localparam int ST_PRIV      = 10;
    localparam int RSP_VALID    = 8;
    localparam int CFG_PRIV     = 0;
    localparam int CFG_DIS      = 1;  // init list disabled
    localparam int CFG_CNT_LSB  = 8;  // 8-bit init command count
    localparam int STORE_A_LSB  = 8;  // store write address field

    // ************************************************************
    // opcodes, modes, windows and sizes
    // ************************************************************
    typedef enum logic [1:0] {
        OP_READ      = 2'h0, // read_user_store_cmd
        OP_SET_ADDR  = 2'h1, // set_public_addr_cmd
        OP_GET_ADDR  = 2'h2, // get_public_addr_cmd
        OP_SET_SLEEP = 2'h3  // set_sleep_level_cmd
    } sds_op_t;

    localparam logic [3:0]  MODE_USER  = 4'h0;
    localparam logic [3:0]  MODE_REG   = 4'h1;
    localparam logic [3:0]  MODE_RAM   = 4'h2;
    localparam logic [3:0]  MODE_INIT  = 4'h3;
    localparam logic [3:0]  MODE_INFO  = 4'h4;
    localparam logic [3:0]  MODE_REG2  = 4'he;
    localparam logic [3:0]  MODE_LIST  = 4'hf;
    localparam logic [31:0] REG_BASE   = 32'h0032_0000;
    localparam logic [31:0] RAM_BASE   = 32'h0022_0000;
    localparam logic [31:0] REG2_BASE  = 32'h0033_0000;
    localparam logic [31:0] INIT_BASE  = 32'h0040_0000; // init list window
    localparam logic [8:0]  STORE_SIZE = 9'h100;
    localparam logic [5:0]  CNT_MIN    = 6'h01;
    localparam logic [5:0]  CNT_MAX    = 6'h20;
    localparam logic [5:0]  REG_BYTES  = 6'h04; // fixed word for register modes
    localparam logic [5:0]  INIT_BYTES = 6'h04; // bytes per stored init command
    localparam logic [5:0]  INFO_BYTES = 6'h02;
    localparam logic [5:0]  ADDR_BYTES = 6'h06;
    localparam logic [7:0]  LIST_MAX   = 8'h08; // init commands that fit 32 bytes
    localparam logic [1:0]  SLP_OFF    = 2'h0;
    localparam logic [1:0]  SLP_NORMAL = 2'h1;
    localparam logic [1:0]  SLP_DEEP   = 2'h2;

    // activity that forbids deep sleep
    typedef struct packed {
        logic radio;
        logic pwm;
        logic uart;
    } sds_act_t;

    // one write into the user store
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } sds_wr_t;

endpackage

/* rtl/sds_store.sv */
// 256-byte user store with registered read data
module sds_store
    import sds_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       ce,
    input  wire sds_wr_t    wr,
    input  wire logic [7:0] raddr,
    output logic      [7:0] rdata
);
    // ************************************************************
    // storage array, no reset: contents model nonvolatile cells
    // ************************************************************
    logic [7:0] mem [256];

    // write and read share the clock enable so a freeze holds both
    always_ff @(posedge pclk) begin
        if (ce) begin
            if (wr.we) begin
                mem[wr.addr] <= wr.data;
            end
            rdata <= mem[raddr];
        end
    end
endmodule // sds_store

/* rtl/sds_buf2.sv */
// two-entry buffer with valid/ready on both sides
module sds_buf2
    import sds_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire logic [7:0] in_data,
    output logic            out_valid,
    input  wire logic       out_ready,
    output logic      [7:0] out_data
);
    typedef struct packed {
        logic [1:0][7:0] ent; // entry 0 is the head
        logic [1:0]      cnt; // 0, 1 or 2 words held
    } sds_buf_t;

    sds_buf_t s_q, s_d;
    logic     push, pop;

    // ************************************************************
    // handshake and next state
    // ************************************************************
    always_comb begin
        in_ready  = (s_q.cnt != 2'h2);
        out_valid = (s_q.cnt != 2'h0);
        out_data  = s_q.ent[0];
        push      = in_valid & in_ready;
        pop       = out_valid & out_ready;
        s_d       = s_q;
        // shift head out first, then land the new word behind what stays
        if (pop) begin
            s_d.ent[0] = s_q.ent[1];
        end
        if (push) begin
            s_d.ent[s_q.cnt - {1'b0, pop}] = in_data;
        end
        s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end
endmodule // sds_buf2

/* rtl/sds_cmd.sv */
// command handler: user store read, public address set/get, sleep level
// Operation
// - 256-byte store, read 1 to 32 bytes
// - binary payload between 3 and 35 bytes
// - text answer spans 13 to 77 characters
// - mode 0 reads store, offset 0 to ff
// - mode 1 reads 0x320000 plus offset
// - mode 2 reads 0x220000 plus offset
// - mode e reads 0x330000 plus offset
// - mode 3 init command, mode 4 info
// - mode f dumps init list, ignores arguments
// - count 1 to 32, used in modes 0,2
// - length byte precedes the data bytes
// - default address is the factory address
// - all-zero set restores factory address
// - privacy presents a random address
// - get returns six-byte address in effect
// - level 0 off, 1 normal, 2 deep
// - no deep sleep during radio, pwm, serial
//
// Design decisions made here: the register offsets and the APB slave port.
module sds_cmd
    import sds_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [47:0] factory_addr,  // chip-derived public address
    input  wire logic [47:0] random_addr,   // private address source
    input  wire sds_act_t    activity_pin,  // asynchronous activity levels
    output logic      [31:0] dbg_addr,      // debug window byte address
    output logic             dbg_req,       // held until dbg_ack
    input  wire logic        dbg_ack,
    input  wire logic [7:0]  dbg_rdata,
    output logic      [47:0] peer_addr,     // address shown to peers
    output logic             sleep_normal_ok,
    output logic             sleep_deep_ok
);
    // ************************************************************
    // types and state
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000, // waiting for a command
        ST_LEN   = 3'b001, // pushing the length byte
        ST_FETCH = 3'b010, // presenting a read address
        ST_WAIT  = 3'b011, // waiting for the byte
        ST_PUSH  = 3'b100  // pushing a data byte
    } sds_st_t;

    typedef enum logic [1:0] {
        SRC_MEM  = 2'h0, // user store
        SRC_DBG  = 2'h1, // debug windows and init list
        SRC_PUB  = 2'h2, // address in effect
        SRC_INFO = 2'h3  // init list info
    } sds_src_t;

    typedef struct packed {
        sds_st_t     st;
        sds_src_t    src;
        logic [5:0]  cnt;      // data bytes still to send
        logic [5:0]  len;      // data bytes in this answer
        logic [31:0] addr;     // running read address
        logic [7:0]  dbyte;    // byte waiting to be pushed
        logic [15:0] arg;
        logic [47:0] new_addr; // staged address for a set
        logic [47:0] pub;      // public address from the last set
        logic        pub_set;  // software address overrides factory
        logic        priv;
        logic        err;
        logic [1:0]  level;
        logic        list_dis;
        logic [7:0]  list_cnt;
        logic [2:0]  s1, s2, s3; // activity synchroniser stages
        logic [2:0]  act;        // accepted activity levels
        logic        dbg_req;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [47:0] peer;
        logic        slp_n;
        logic        slp_d;
    } sds_state_t;

    sds_state_t s_q, s_d;

    // store, buffer and helper wires
    sds_wr_t     st_wr;       // store write port
    logic [7:0]  st_rdata;    // store read data, one cycle after fetch
    logic        buf_in_valid;
    logic        buf_in_ready;
    logic [7:0]  buf_in_data;
    logic        buf_out_valid;
    logic        buf_out_ready;
    logic [7:0]  buf_out_data;
    logic        setup;       // apb setup cycle
    logic        wr_en;
    logic        rd_en;
    logic [3:0]  mode;
    logic [5:0]  cnt_arg;
    logic [8:0]  span;
    logic [47:0] eff_addr;
    logic [7:0]  nlist;

    // ************************************************************
    // submodules
    // ************************************************************
    sds_store u_store (
        .pclk  (pclk),
        .ce    (ce),
        .wr    (st_wr),
        .raddr (s_q.addr[7:0]),
        .rdata (st_rdata)
    );

    // a stalled reader backs up here and holds the command engine
    sds_buf2 u_buf (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_data),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        s_d           = s_q;
        setup         = psel & ~penable & ~s_q.pready;
        wr_en         = setup & pwrite;
        rd_en         = setup & ~pwrite;
        mode          = pwdata[CMD_MODE_LSB +: 4];
        cnt_arg       = pwdata[CMD_CNT_LSB +: 6];
        span          = {1'b0, s_q.arg[7:0]} + {3'b000, cnt_arg};
        // user overrides factory only while an override is held
        eff_addr      = s_q.pub_set ? s_q.pub : factory_addr;
        nlist         = (s_q.list_cnt > LIST_MAX) ? LIST_MAX : s_q.list_cnt;
        st_wr.we      = wr_en & (paddr == OFS_STORE);
        st_wr.addr    = pwdata[STORE_A_LSB +: 8];
        st_wr.data    = pwdata[7:0];
        buf_in_valid  = 1'b0;
        buf_in_data   = s_q.dbyte;
        buf_out_ready = rd_en & (paddr == OFS_RSP);

        // apb slave: answer in the access cycle right after setup
        s_d.pready  = setup;
        s_d.pslverr = 1'b0;
        s_d.prdata  = '0;
        if (rd_en) begin
            case (paddr)
                OFS_ARG:     s_d.prdata = {16'h0000, s_q.arg};
                OFS_NEWA_LO: s_d.prdata = s_q.new_addr[31:0];
                OFS_NEWA_HI: s_d.prdata = {16'h0000, s_q.new_addr[47:32]};
                OFS_STATUS: begin
                    s_d.prdata[ST_BUSY]          = (s_q.st != ST_IDLE);
                    s_d.prdata[ST_ERR]           = s_q.err;
                    s_d.prdata[ST_SLP_LSB +: 2]  = s_q.level;
                    s_d.prdata[ST_NORM]          = s_q.slp_n;
                    s_d.prdata[ST_DEEP]          = s_q.slp_d;
                    s_d.prdata[ST_PRIV]          = s_q.priv;
                end
                OFS_RSP: begin
                    s_d.prdata[7:0]       = buf_out_data;
                    s_d.prdata[RSP_VALID] = buf_out_valid;
                end
                OFS_CURA_LO: s_d.prdata = eff_addr[31:0];
                OFS_CURA_HI: s_d.prdata = {16'h0000, eff_addr[47:32]};
                OFS_CFG: begin
                    s_d.prdata[CFG_PRIV]         = s_q.priv;
                    s_d.prdata[CFG_DIS]          = s_q.list_dis;
                    s_d.prdata[CFG_CNT_LSB +: 8] = s_q.list_cnt;
                end
                OFS_CMD, OFS_STORE: s_d.prdata = '0; // write-only
                default: s_d.pslverr = 1'b1;      // unmapped
            endcase
        end
        if (wr_en) begin
            case (paddr)
                OFS_ARG:     s_d.arg = pwdata[15:0];
                OFS_NEWA_LO: s_d.new_addr[31:0] = pwdata;
                OFS_NEWA_HI: s_d.new_addr[47:32] = pwdata[15:0];
                OFS_CFG: begin
                    s_d.priv     = pwdata[CFG_PRIV];
                    s_d.list_dis = pwdata[CFG_DIS];
                    s_d.list_cnt = pwdata[CFG_CNT_LSB +: 8];
                end
                OFS_CMD, OFS_STORE: s_d.pslverr = 1'b0; // command launched below, store write decoded above
                default: s_d.pslverr = 1'b1;
            endcase
        end

        // command launch; a command while busy is refused with an error
        if (wr_en && (paddr == OFS_CMD)) begin
            s_d.err = 1'b0;
            if (s_q.st != ST_IDLE) begin
                s_d.err = 1'b1;
            end else begin
                case (sds_op_t'(pwdata[CMD_OP_LSB +: 2]))
                    OP_SET_ADDR: begin
                        s_d.pub_set = (s_q.new_addr != '0); // zeros: factory address
                        s_d.pub     = s_q.new_addr;
                    end
                    OP_GET_ADDR: begin
                        s_d.src = SRC_PUB;
                        s_d.len = ADDR_BYTES;
                        s_d.st  = ST_LEN;
                    end
                    OP_SET_SLEEP: begin
                        // level sits in the argument register: the opcode owns bits 1:0
                        s_d.err   = (s_q.arg > {14'h0000, SLP_DEEP});
                        s_d.level = s_d.err ? s_q.level : s_q.arg[1:0];
                    end
                    OP_READ: begin
                        s_d.st  = ST_LEN;
                        s_d.src = SRC_DBG;
                        s_d.len = REG_BYTES;
                        case (mode)
                            MODE_USER: begin
                                s_d.src  = SRC_MEM;
                                s_d.len  = cnt_arg;
                                s_d.addr = {24'h000000, s_q.arg[7:0]};
                                // offset above ff, bad count or overrun
                                if ((s_q.arg[15:8] != 8'h00) ||
                                    (cnt_arg < CNT_MIN) || (cnt_arg > CNT_MAX) ||
                                    (span > STORE_SIZE)) begin
                                    s_d.err = 1'b1;
                                    s_d.st  = ST_IDLE;
                                end
                            end
                            MODE_REG:  s_d.addr = REG_BASE + {16'h0000, s_q.arg};
                            MODE_REG2: s_d.addr = REG2_BASE + {16'h0000, s_q.arg};
                            MODE_RAM: begin
                                s_d.addr = RAM_BASE + {16'h0000, s_q.arg};
                                s_d.len  = cnt_arg;
                                if ((cnt_arg < CNT_MIN) || (cnt_arg > CNT_MAX)) begin
                                    s_d.err = 1'b1;
                                    s_d.st  = ST_IDLE;
                                end
                            end
                            MODE_INIT: begin
                                s_d.len  = INIT_BYTES;
                                s_d.addr = INIT_BASE + {16'h0000, s_q.arg[13:0], 2'b00};
                            end
                            MODE_INFO: begin
                                s_d.src = SRC_INFO;
                                s_d.len = INFO_BYTES;
                            end
                            MODE_LIST: begin
                                s_d.addr = INIT_BASE; // offset and count unused
                                s_d.len  = {nlist[3:0], 2'b00};
                            end
                            default: begin
                                s_d.err = 1'b1;
                                s_d.st  = ST_IDLE;
                            end
                        endcase
                    end
                    default: s_d.err = 1'b1;
                endcase
            end
        end

        // response engine; a full buffer holds it in place
        case (s_q.st)
            ST_IDLE: s_d.dbyte = s_q.dbyte;
            ST_LEN: begin
                buf_in_valid = 1'b1;
                buf_in_data  = {2'b00, s_q.len};
                if (buf_in_ready) begin
                    s_d.cnt = s_q.len;
                    s_d.st  = (s_q.len == '0) ? ST_IDLE : ST_FETCH;
                end
            end
            ST_FETCH: begin
                s_d.st      = ST_WAIT;
                s_d.dbg_req = (s_q.src == SRC_DBG);
            end
            ST_WAIT: begin
                case (s_q.src)
                    SRC_MEM: begin
                        s_d.dbyte = st_rdata;
                        s_d.st    = ST_PUSH;
                    end
                    SRC_DBG: begin
                        if (dbg_ack) begin
                            s_d.dbyte   = dbg_rdata;
                            s_d.dbg_req = 1'b0;
                            s_d.st      = ST_PUSH;
                        end
                    end
                    SRC_PUB: begin
                        s_d.dbyte = eff_addr[s_q.addr[2:0] * 8 +: 8];
                        s_d.st    = ST_PUSH;
                    end
                    default: begin
                        s_d.dbyte = s_q.addr[0] ? s_q.list_cnt
                                                : {7'h00, s_q.list_dis};
                        s_d.st    = ST_PUSH;
                    end
                endcase
            end
            ST_PUSH: begin
                buf_in_valid = 1'b1;
                if (buf_in_ready) begin
                    s_d.cnt  = s_q.cnt - 6'h01;
                    s_d.addr = s_q.addr + 32'h0000_0001;
                    s_d.st   = (s_q.cnt == 6'h01) ? ST_IDLE : ST_FETCH;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
        if ((s_q.st == ST_IDLE) && (s_d.st == ST_LEN) && (s_d.src >= SRC_PUB)) begin
            s_d.addr = '0; // address bytes and info walk from byte 0
        end

        // activity pins: three stages, change taken when stages 2 and 3 agree
        s_d.s1 = activity_pin;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        for (int i = 0; i < 3; i++) begin
            if (s_q.s2[i] == s_q.s3[i]) begin
                s_d.act[i] = s_q.s3[i];
            end
        end

        // sleep permission from configured level and activity
        s_d.slp_n = (s_q.level != SLP_OFF);
        s_d.slp_d = (s_q.level == SLP_DEEP) && (s_q.act == 3'b000);
        // peers see the random address while privacy is on
        s_d.peer  = s_q.priv ? random_addr : eff_addr;
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state flip-flops
    assign prdata          = s_q.prdata;
    assign pready          = s_q.pready;
    assign pslverr         = s_q.pslverr;
    assign dbg_addr        = s_q.addr;
    assign dbg_req         = s_q.dbg_req;
    assign peer_addr       = s_q.peer;
    assign sleep_normal_ok = s_q.slp_n;
    assign sleep_deep_ok   = s_q.slp_d;
endmodule // sds_cmd

/* verif/sds_dbg_model.sv */
// debug memory responder on the far side of the debug port
module sds_dbg_model
    import sds_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic [31:0] dbg_addr,
    input  wire logic        dbg_req,
    output logic             dbg_ack,
    output logic       [7:0] dbg_rdata
);
    timeunit 1ns; timeprecision 100ps;
    logic [1:0] wait_q = 2'h0; // cycles waited on this request
    // odd addresses answer late, so the request must be held
    always_ff @(posedge pclk) wait_q <= (dbg_req && !dbg_ack) ? wait_q + 2'h1 : 2'h0;
    assign dbg_ack = dbg_req && (wait_q == (dbg_addr[0] ? 2'h3 : 2'h0));
    // address pattern, inverted until acknowledged
    assign dbg_rdata = dbg_addr[7:0] ^ dbg_addr[23:16] ^ {8{!dbg_ack}};
endmodule // sds_dbg_model

/* verif/sds_monitor.sv */
// port checker of the command handler
module sds_monitor
    import sds_pkg::*;
(
    input wire logic        pclk, presetn, ce, psel, penable, pready, pslverr,
    input wire logic [7:0]  paddr,
    input wire sds_act_t    activity_pin,
    input wire logic [31:0] dbg_addr,
    input wire logic        dbg_req, dbg_ack, sleep_normal_ok, sleep_deep_ok
);
    timeunit 1ns; timeprecision 100ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_apb_answer: assert property (psel && !penable && ce |=> pready) else $error("no answer");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_unmapped_err: assert property (psel && !penable && paddr > 8'h24 |=> pslverr)
        else $error("no slave error");
    a_dbg_hold: assert property (dbg_req && !dbg_ack |=> dbg_req && $stable(dbg_addr))
        else $error("debug request dropped");
    a_dbg_drop: assert property (dbg_req && dbg_ack |=> !dbg_req) else $error("debug held");
    a_dbg_window: assert property (dbg_req |-> dbg_addr inside {[32'h0022_0000:32'h0044_0000]})
        else $error("debug address off window");
    a_deep_norm: assert property (sleep_deep_ok |-> sleep_normal_ok) else $error("deep alone");
    // synchroniser lag: only a long run of activity is judged
    a_deep_busy: assert property ((|activity_pin) [*8] |-> !sleep_deep_ok)
        else $error("deep while active");
    cover property (dbg_req && dbg_ack);
    cover property (pready && pslverr);
    cover property (|activity_pin);
endmodule // sds_monitor
bind sds_cmd sds_monitor u_mon (.pclk, .presetn, .ce, .psel, .penable, .pready, .pslverr,
    .paddr, .activity_pin, .dbg_addr, .dbg_req, .dbg_ack, .sleep_normal_ok, .sleep_deep_ok);

/* verif/tb_top.sv */
// self-checking bench of the command handler
module tb_top;
    timeunit 1ns; timeprecision 100ps;
    import sds_pkg::*;
    typedef struct packed {logic [3:0] m; logic [15:0] o; logic [5:0] n; logic [7:0] len;} sds_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [7:0] paddr = 8'h00, dbg_rdata;
    logic [31:0] pwdata = 32'h0, prdata, dbg_addr, rd;
    logic [47:0] peer_addr, fac = 48'h0a1b2c3d4e5f, rnd = 48'h0f0e0d0c0b0a;
    sds_act_t act = '0;
    logic dbg_req, dbg_ack, sn_ok, sd_ok;
    int err_total = 0, checks = 0;
    sds_row_t rows [8] = '{'{MODE_USER, 16'h00e0, 6'h20, 8'h20}, '{MODE_USER, 16'h0, 6'h01, 8'h01},
        '{MODE_REG, 16'h0011, 6'h01, 8'h04}, '{MODE_RAM, 16'h0100, 6'h03, 8'h03},
        '{MODE_REG2, 16'hfff0, 6'h09, 8'h04}, '{MODE_INIT, 16'h0002, 6'h01, 8'h04},
        '{MODE_INFO, 16'h0007, 6'h01, 8'h02}, '{MODE_LIST, 16'h0033, 6'h05, 8'h14}};
    logic [31:0] bad [5] = '{32'h00e1_2000, 32'h0, 32'h0000_2100, 32'h0100_0100, 32'h0003_0003};
    always #12.5 pclk = ~pclk;
    sds_cmd uut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .factory_addr(fac), .random_addr(rnd), .activity_pin(act), .dbg_addr,
        .dbg_req, .dbg_ack, .dbg_rdata, .peer_addr, .sleep_normal_ok(sn_ok), .sleep_deep_ok(sd_ok));
    sds_dbg_model u_dbg (.pclk, .dbg_addr, .dbg_req, .dbg_ack, .dbg_rdata);
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        checks++;
        if (g !== e) begin err_total++; $display("MISMATCH %0t got %h want %h", $time, g, e); end
    endtask
    // apb transfer until pready at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk) begin psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; end
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    endtask
    task automatic pop(input logic [7:0] e);
        repeat (200) begin apb(0, OFS_RSP, 0); if (rd[RSP_VALID] === 1'b1) break; end
        chk(48'(rd[8:0]), 48'({1'b1, e}));
    endtask
    task automatic idle;
        repeat (200) begin apb(0, OFS_STATUS, 0); if (rd[ST_BUSY] === 1'b0) break; end
    endtask
    function automatic logic [7:0] ex(logic [3:0] m, logic [15:0] o, int i);
        logic [31:0] a;
        a = m == MODE_REG ? REG_BASE : m == MODE_RAM ? RAM_BASE : m == MODE_REG2 ? REG2_BASE : INIT_BASE;
        a = a + (m == MODE_INIT ? 32'(o) * 4 : m == MODE_LIST ? 32'h0 : 32'(o)) + 32'(i);
        if (m == MODE_USER) return 8'(o + i) ^ 8'h3c;
        if (m == MODE_INFO) return i ? 8'h05 : 8'h00;
        return a[7:0] ^ a[23:16];
    endfunction
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        apb(0, OFS_STATUS, 0);
        chk(48'({rd[5:4], sn_ok}), 48'h0);
        chk(peer_addr, fac);
        for (int i = 0; i < 256; i++) apb(1, OFS_STORE, {16'h0, 8'(i), 8'(i) ^ 8'h3c});
        apb(1, OFS_CFG, 32'h0500);
        foreach (rows[k]) begin
            apb(1, OFS_ARG, 32'(rows[k].o));
            apb(1, OFS_CMD, {16'h0, 2'h0, rows[k].n, rows[k].m, 4'h0});
            pop(rows[k].len);
            for (int i = 0; i < rows[k].len; i++) pop(ex(rows[k].m, rows[k].o, i));
            $display("read row %0d done", k);
        end
        foreach (bad[k]) begin
            apb(1, OFS_ARG, bad[k] >> 16);
            apb(1, OFS_CMD, {16'h0, bad[k][15:0]});
            idle;
            chk(48'(rd[ST_ERR]), 48'h1);
            apb(0, OFS_RSP, 0);
            chk(48'(rd[RSP_VALID]), 48'h0);
        end
        $display("refusals done");
        apb(1, OFS_NEWA_LO, 32'h44332211);
        apb(1, OFS_NEWA_HI, 32'h6655);
        apb(1, OFS_CMD, 32'h1);
        idle;
        apb(1, OFS_CMD, 32'h2);
        for (int i = 0; i < 7; i++) pop(i ? 8'(i * 17) : 8'h06);
        chk(peer_addr, 48'h665544332211);
        apb(1, OFS_NEWA_LO, 0);
        apb(1, OFS_NEWA_HI, 0);
        apb(1, OFS_CMD, 32'h1);
        idle;
        apb(0, OFS_CURA_LO, 0);
        chk(48'(rd), 48'(fac[31:0]));
        apb(1, OFS_CFG, 32'h0501);
        apb(0, 8'h40, 0);
        chk(48'(er), 48'h1);
        chk(peer_addr, rnd);
        apb(1, OFS_ARG, 2);
        apb(1, OFS_CMD, 3);
        idle;
        chk(48'({rd[ST_ERR], sn_ok, sd_ok}), 48'h3);
        act <= 3'h4;
        repeat (12) @(posedge pclk);
        chk(48'({sn_ok, sd_ok}), 48'h2);
        $display("address and sleep done");
        give_verdict;
    end
    initial begin #2000000; err_total++; give_verdict; end
endmodule // tb_top
